// ---- hw/bsf_params.svh ----
// offsets, field positions, reset values, tag codes and edge counts of the sample buffer block
`ifndef BSF_PARAMS_SVH
`define BSF_PARAMS_SVH
`define BSF_OFF_CTRL 5'h00
`define BSF_OFF_THRESH 5'h04
`define BSF_OFF_CMD 5'h08
`define BSF_OFF_STATUS 5'h0c
`define BSF_OFF_HEAD 5'h10
`define BSF_CTRL_TARGET_BIT 0
`define BSF_CTRL_BURST_BIT 1
`define BSF_CTRL_RESET 2'h0
`define BSF_THR_ECG_LSB 0
`define BSF_THR_BIOZ_LSB 8
`define BSF_THR_ECG_RESET 5'h00
`define BSF_THR_BIOZ_RESET 3'h0
`define BSF_CMD_CLEAR_BIT 0
`define BSF_CMD_RESYNC_BIT 1
`define BSF_ST_ECG_INT_BIT 0
`define BSF_ST_ECG_OVF_BIT 1
`define BSF_ST_BIOZ_INT_BIT 2
`define BSF_ST_BIOZ_OVF_BIT 3
`define BSF_ST_ECG_CNT_LSB 8
`define BSF_ST_BIOZ_CNT_LSB 16
`define BSF_TAG_VALID 3'h0
`define BSF_TAG_FLAGGED 3'h1
`define BSF_TAG_VALID_EOF 3'h2
`define BSF_TAG_FLAGGED_EOF 3'h3
`define BSF_TAG_EMPTY 3'h6
`define BSF_TAG_OVERFLOW 3'h7
`define BSF_PACE_NONE 3'h7
`define BSF_PACE_LAST_GROUP 3'h5
`define BSF_FIRST_WORD_EDGES 6'h20
`define BSF_BURST_WORD_EDGES 6'h18
`define BSF_BURST_MAX_WORDS 6'h20
`endif

// ---- hw/bsf_pkg.sv ----
// types shared by the sample buffer block
package bsf_pkg;
  typedef enum logic [1:0]
  {
    BSF_LK_IDLE = 2'b00,
    BSF_LK_FIRST = 2'b01,
    BSF_LK_BURST = 2'b11,
    BSF_LK_DONE = 2'b10
  } bsf_link_e;
  typedef logic [2:0] bsf_tag_t;
endpackage : bsf_pkg

// ---- hw/bsf_sample_fifo.sv ----
// ecg and bioimpedance sample buffers with tagging, serial-clock read advance and avalon-mm registers
`include "bsf_params.svh"
module bsf_sample_fifo #(
  parameter int ECG_DEPTH = 32,
  parameter int BIOZ_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic spi_sclk,
  input wire logic spi_csb_n,
  input wire logic ecg_sample_valid,
  input wire logic [17:0] ecg_sample_data,
  input wire logic ecg_sample_fast,
  input wire logic ecg_pace_hit,
  input wire logic [2:0] ecg_pace_group,
  input wire logic bioz_sample_valid,
  input wire logic [19:0] bioz_sample_data,
  input wire logic bioz_out_of_range,
  output logic [23:0] head_word,
  output logic ecg_fill_interrupt,
  output logic ecg_overrun_flag,
  output logic bioz_fill_interrupt,
  output logic bioz_overrun_flag,
  output logic channel_resync_command
);
  localparam int EPW = $clog2(ECG_DEPTH);
  localparam int ECW = $clog2(ECG_DEPTH + 1);
  localparam int BPW = $clog2(BIOZ_DEPTH);
  localparam int BCW = $clog2(BIOZ_DEPTH + 1);
  // one status code scheme serves both buffers; overflow outranks empty
  function automatic bsf_pkg::bsf_tag_t status_tag(input logic ovf, input logic empty, input logic last,
                                                   input logic flagged);
    if (ovf)
      status_tag = `BSF_TAG_OVERFLOW;
    else if (empty)
      status_tag = `BSF_TAG_EMPTY;
    else if (last)
      status_tag = flagged ? `BSF_TAG_FLAGGED_EOF : `BSF_TAG_VALID_EOF;
    else
      status_tag = flagged ? `BSF_TAG_FLAGGED : `BSF_TAG_VALID;
  endfunction : status_tag
  // register bus
  logic wait_q;
  logic [31:0] rdata_q;
  logic [1:0] ctrl_q;
  logic [4:0] ecg_fill_threshold_q;
  logic [2:0] bioz_fill_threshold_q;
  logic clear_q;
  logic resync_q;
  logic [31:0] rdata_d;
  logic req;
  logic accept;
  logic [ECW-1:0] ecg_cnt_q;
  logic [BCW-1:0] bioz_cnt_q;
  logic ecg_ovf_q;
  logic bioz_ovf_q;
  logic ecg_int_q;
  logic bioz_int_q;
  logic [23:0] head_q;
  assign req = avs_read | avs_write;
  assign accept = req & ~wait_q;
  // one wait cycle per request, then a single cycle with waitrequest low
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wait_q <= 1'b1;
    else
      wait_q <= ~(req & wait_q);
  end
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address)
      `BSF_OFF_CTRL:
        rdata_d[1:0] = ctrl_q;
      `BSF_OFF_THRESH:
      begin
        rdata_d[`BSF_THR_ECG_LSB +: 5] = ecg_fill_threshold_q;
        rdata_d[`BSF_THR_BIOZ_LSB +: 3] = bioz_fill_threshold_q;
      end
      `BSF_OFF_STATUS:
      begin
        rdata_d[`BSF_ST_ECG_INT_BIT] = ecg_int_q;
        rdata_d[`BSF_ST_ECG_OVF_BIT] = ecg_ovf_q;
        rdata_d[`BSF_ST_BIOZ_INT_BIT] = bioz_int_q;
        rdata_d[`BSF_ST_BIOZ_OVF_BIT] = bioz_ovf_q;
        rdata_d[`BSF_ST_ECG_CNT_LSB +: ECW] = ecg_cnt_q;
        rdata_d[`BSF_ST_BIOZ_CNT_LSB +: BCW] = bioz_cnt_q;
      end
      `BSF_OFF_HEAD:
        rdata_d[23:0] = head_q;
      default:
        rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && wait_q)
      rdata_q <= rdata_d;
  end
  // thresholds hold the count minus one, so every code is a legal 1..N threshold
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= `BSF_CTRL_RESET;
      ecg_fill_threshold_q <= `BSF_THR_ECG_RESET;
      bioz_fill_threshold_q <= `BSF_THR_BIOZ_RESET;
    end
    else if (accept && avs_write && avs_address == `BSF_OFF_CTRL)
      ctrl_q <= avs_writedata[1:0];
    else if (accept && avs_write && avs_address == `BSF_OFF_THRESH)
    begin
      ecg_fill_threshold_q <= avs_writedata[`BSF_THR_ECG_LSB +: 5];
      bioz_fill_threshold_q <= avs_writedata[`BSF_THR_BIOZ_LSB +: 3];
    end
  end
  // command strobes last one cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clear_q <= 1'b0;
      resync_q <= 1'b0;
    end
    else
    begin
      clear_q <= accept & avs_write & (avs_address == `BSF_OFF_CMD) & avs_writedata[`BSF_CMD_CLEAR_BIT];
      resync_q <= accept & avs_write & (avs_address == `BSF_OFF_CMD) & avs_writedata[`BSF_CMD_RESYNC_BIT];
    end
  end
  // serial clock sampling: only the second stage and its delayed copy feed logic
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic csb_s1_q;
  logic csb_s2_q;
  logic sclk_rise;
  bsf_pkg::bsf_link_e link_q;
  logic [5:0] edge_cnt_q;
  logic [5:0] word_cnt_q;
  logic advance_q;
  logic frame_limit;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      csb_s1_q <= 1'b1;
      csb_s2_q <= 1'b1;
    end
    else
    begin
      sclk_s1_q <= spi_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      csb_s1_q <= spi_csb_n;
      csb_s2_q <= csb_s1_q;
    end
  end
  assign sclk_rise = sclk_s2_q & ~sclk_s3_q & ~csb_s2_q;
  assign frame_limit = (link_q == bsf_pkg::BSF_LK_FIRST) ? (edge_cnt_q == `BSF_FIRST_WORD_EDGES - 6'h01)
                                                          : (edge_cnt_q == `BSF_BURST_WORD_EDGES - 6'h01);
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_q <= bsf_pkg::BSF_LK_IDLE;
      edge_cnt_q <= 6'h00;
      word_cnt_q <= 6'h00;
      advance_q <= 1'b0;
    end
    else
    begin
      advance_q <= 1'b0;
      if (csb_s2_q)
      begin
        link_q <= bsf_pkg::BSF_LK_IDLE;
        edge_cnt_q <= 6'h00;
        word_cnt_q <= 6'h00;
      end
      else
      begin
        unique case (link_q)
          bsf_pkg::BSF_LK_IDLE:
            link_q <= bsf_pkg::BSF_LK_FIRST;
          bsf_pkg::BSF_LK_FIRST, bsf_pkg::BSF_LK_BURST:
          begin
            if (sclk_rise && frame_limit)
            begin
              advance_q <= 1'b1;
              edge_cnt_q <= 6'h00;
              word_cnt_q <= word_cnt_q + 6'h01;
              if (!ctrl_q[`BSF_CTRL_BURST_BIT] || word_cnt_q == `BSF_BURST_MAX_WORDS - 6'h01)
                link_q <= bsf_pkg::BSF_LK_DONE;
              else
                link_q <= bsf_pkg::BSF_LK_BURST;
            end
            else if (sclk_rise)
              edge_cnt_q <= edge_cnt_q + 6'h01;
          end
          bsf_pkg::BSF_LK_DONE:
            link_q <= bsf_pkg::BSF_LK_DONE;
        endcase
      end
    end
  end
  // buffers
  logic [21:0] ecg_mem [ECG_DEPTH];
  logic [20:0] bioz_mem [BIOZ_DEPTH];
  logic [EPW-1:0] ecg_wr_q;
  logic [EPW-1:0] ecg_rd_q;
  logic [BPW-1:0] bioz_wr_q;
  logic [BPW-1:0] bioz_rd_q;
  logic flush;
  logic ecg_pop;
  logic bioz_pop;
  logic ecg_full;
  logic bioz_full;
  logic ecg_store;
  logic bioz_store;
  logic [2:0] pace_code;
  logic [21:0] ecg_head;
  logic [20:0] bioz_head;
  assign flush = clear_q | resync_q;
  assign ecg_pop = advance_q & ~ctrl_q[`BSF_CTRL_TARGET_BIT] & (ecg_cnt_q != '0);
  assign bioz_pop = advance_q & ctrl_q[`BSF_CTRL_TARGET_BIT] & (bioz_cnt_q != '0);
  assign ecg_full = ecg_cnt_q == ECW'(ECG_DEPTH);
  assign bioz_full = bioz_cnt_q == BCW'(BIOZ_DEPTH);
  // a full buffer drops the new sample rather than overwrite the unread head
  assign ecg_store = ecg_sample_valid & (~ecg_full | ecg_pop);
  assign bioz_store = bioz_sample_valid & (~bioz_full | bioz_pop);
  // out-of-range group falls back to none
  assign pace_code = (ecg_pace_hit && ecg_pace_group <= `BSF_PACE_LAST_GROUP) ? ecg_pace_group : `BSF_PACE_NONE;
  always_ff @(posedge clk_sys)
  begin
    if (ecg_store)
      ecg_mem[ecg_wr_q] <= {ecg_sample_data, ecg_sample_fast, pace_code};
    if (bioz_store)
      bioz_mem[bioz_wr_q] <= {bioz_sample_data, bioz_out_of_range};
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ecg_wr_q <= '0;
      ecg_rd_q <= '0;
      ecg_cnt_q <= '0;
    end
    else if (flush)
    begin
      ecg_wr_q <= '0;
      ecg_rd_q <= '0;
      ecg_cnt_q <= '0;
    end
    else
    begin
      ecg_wr_q <= ecg_wr_q + EPW'(ecg_store);
      ecg_rd_q <= ecg_rd_q + EPW'(ecg_pop);
      ecg_cnt_q <= ecg_cnt_q + ECW'(ecg_store) - ECW'(ecg_pop);
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bioz_wr_q <= '0;
      bioz_rd_q <= '0;
      bioz_cnt_q <= '0;
    end
    else if (flush)
    begin
      bioz_wr_q <= '0;
      bioz_rd_q <= '0;
      bioz_cnt_q <= '0;
    end
    else
    begin
      bioz_wr_q <= bioz_wr_q + BPW'(bioz_store);
      bioz_rd_q <= bioz_rd_q + BPW'(bioz_pop);
      bioz_cnt_q <= bioz_cnt_q + BCW'(bioz_store) - BCW'(bioz_pop);
    end
  end
  // overflow stays until a flush; a flush in the overflowing cycle loses to the new overflow
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ecg_ovf_q <= 1'b0;
      bioz_ovf_q <= 1'b0;
    end
    else
    begin
      ecg_ovf_q <= (ecg_sample_valid & ecg_full & ~ecg_pop) | (ecg_ovf_q & ~flush);
      bioz_ovf_q <= (bioz_sample_valid & bioz_full & ~bioz_pop) | (bioz_ovf_q & ~flush);
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ecg_int_q <= 1'b0;
      bioz_int_q <= 1'b0;
    end
    else
    begin
      ecg_int_q <= ecg_cnt_q > ECW'(ecg_fill_threshold_q);
      bioz_int_q <= bioz_cnt_q > BCW'(bioz_fill_threshold_q);
    end
  end
  assign ecg_head = ecg_mem[ecg_rd_q];
  assign bioz_head = bioz_mem[bioz_rd_q];
  // the word the serial shifter sends next; an empty buffer sends zero data so no stale or unwritten entry leaks
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      head_q <= 24'h00_0000;
    else if (!ctrl_q[`BSF_CTRL_TARGET_BIT])
    begin
      head_q <= {(ecg_cnt_q == '0) ? 18'h0_0000 : ecg_head[21:4],
                 status_tag(ecg_ovf_q, ecg_cnt_q == '0, ecg_cnt_q == ECW'(1), ecg_head[3]),
                 (ecg_cnt_q == '0) ? `BSF_PACE_NONE : ecg_head[2:0]};
    end
    else
    begin
      head_q <= {(bioz_cnt_q == '0) ? 20'h0_0000 : bioz_head[20:1], 1'b0,
                 status_tag(bioz_ovf_q, bioz_cnt_q == '0, bioz_cnt_q == BCW'(1), bioz_head[0])};
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign head_word = head_q;
  assign ecg_fill_interrupt = ecg_int_q;
  assign ecg_overrun_flag = ecg_ovf_q;
  assign bioz_fill_interrupt = bioz_int_q;
  assign bioz_overrun_flag = bioz_ovf_q;
  assign channel_resync_command = resync_q;
endmodule : bsf_sample_fifo

// ---- tb/bsf_sample_fifo_chk.sv ----
// port assertions for the sample buffer block
module bsf_sample_fifo_chk #(
  parameter int ECG_DEPTH = 32,
  parameter int BIOZ_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic ecg_sample_valid,
  input wire logic bioz_sample_valid,
  input wire logic [23:0] head_word,
  input wire logic ecg_overrun_flag,
  input wire logic bioz_overrun_flag,
  input wire logic channel_resync_command
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic acc_w;
  logic cmd_w;
  logic [3:0] tgt_q;
  logic [3:0] age_q;
  assign acc_w = avs_write && !avs_waitrequest;
  assign cmd_w = acc_w && avs_address == 5'h08 && avs_writedata[1:0] != 2'h0;
  // target history: head_word lags a target change, so only a steady target is judged
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      tgt_q <= 4'h0;
    else
      tgt_q <= {tgt_q[2:0], (acc_w && avs_address == 5'h00) ? avs_writedata[0] : tgt_q[0]};
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      age_q <= 4'h0;
    else if (cmd_w)
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
  pace_unused_a: assert property (tgt_q == 4'h0 |-> head_word[2:0] != 3'h6)
    else $error("pace tag shows the unused code");
  bioz_zero_a: assert property (tgt_q == 4'hf |-> !head_word[3])
    else $error("bioz fixed bit not zero");
  ecg_ovf_tag_a: assert property ((tgt_q == 4'h0 && ecg_overrun_flag) [*3] |-> head_word[5:3] == 3'h7)
    else $error("ecg overflow tag missing");
  bioz_ovf_tag_a: assert property ((tgt_q == 4'hf && bioz_overrun_flag) [*3] |-> head_word[2:0] == 3'h7)
    else $error("bioz overflow tag missing");
  cmd_clears_a: assert property (cmd_w && !ecg_sample_valid && !bioz_sample_valid
    |-> ##[1:3] !ecg_overrun_flag && !bioz_overrun_flag)
    else $error("command left an overflow set");
  resync_pulse_a: assert property (cmd_w && avs_writedata[1] |-> ##[1:2] channel_resync_command)
    else $error("resync pulse missing");
  pulse_once_a: assert property (channel_resync_command |=> !channel_resync_command)
    else $error("resync pulse too long");
  ovf_sticky_a: assert property ($fell(ecg_overrun_flag) || $fell(bioz_overrun_flag) |-> age_q < 4'h4)
    else $error("overflow dropped without a command");
endmodule : bsf_sample_fifo_chk

bind bsf_sample_fifo bsf_sample_fifo_chk #(.ECG_DEPTH(ECG_DEPTH), .BIOZ_DEPTH(BIOZ_DEPTH)) u_chk (
  .clk_sys, .reset_n, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest, .ecg_sample_valid,
  .bioz_sample_valid, .head_word, .ecg_overrun_flag, .bioz_overrun_flag, .channel_resync_command);

// ---- tb/bsf_host_model.sv ----
// host serial master: frames of sclk rising edges, sclk idle low outside frames
module bsf_host_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [10:0] n_edges,
  output logic spi_sclk,
  output logic spi_csb_n,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] rise_q = 11'h0;
  logic [1:0] ph_q = 2'h0;
  initial
  begin
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    busy = 1'b0;
  end
  // four clk_sys per half period gives the 400 ns serial clock
  always @(posedge clk_sys)
    if (go)
    begin
      busy <= 1'b1;
      spi_csb_n <= 1'b0;
      rise_q <= 11'h0;
      ph_q <= 2'h0;
    end
    else if (busy)
    begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3 && rise_q == n_edges && !spi_sclk)
      begin
        spi_csb_n <= 1'b1;
        busy <= 1'b0;
      end
      else if (ph_q == 2'h3)
      begin
        spi_sclk <= !spi_sclk;
        if (!spi_sclk)
          rise_q <= rise_q + 11'h1;
      end
    end
endmodule : bsf_host_model

// ---- tb/test_bsf_sample_fifo.sv ----
// self-checking bench for the sample buffer block
module test_bsf_sample_fifo;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic spi_sclk, spi_csb_n, busy;
  logic go = 1'b0;
  logic [10:0] n_edges = 11'h0;
  logic ecg_sample_valid = 1'b0;
  logic [17:0] ecg_sample_data = 18'h0;
  logic ecg_sample_fast = 1'b0;
  logic ecg_pace_hit = 1'b0;
  logic [2:0] ecg_pace_group = 3'h0;
  logic bioz_sample_valid = 1'b0;
  logic [19:0] bioz_sample_data = 20'h0;
  logic bioz_out_of_range = 1'b0;
  logic [23:0] head_word;
  logic ecg_fill_interrupt, ecg_overrun_flag, bioz_fill_interrupt, bioz_overrun_flag, channel_resync_command;
  logic [31:0] rd;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_pulse = 0;
  always #25 clk_sys = !clk_sys;
  bsf_sample_fifo u_dut (.clk_sys, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .spi_sclk, .spi_csb_n, .ecg_sample_valid, .ecg_sample_data,
    .ecg_sample_fast, .ecg_pace_hit, .ecg_pace_group, .bioz_sample_valid, .bioz_sample_data,
    .bioz_out_of_range, .head_word, .ecg_fill_interrupt, .ecg_overrun_flag, .bioz_fill_interrupt,
    .bioz_overrun_flag, .channel_resync_command);
  bsf_host_model u_host (.clk_sys, .go, .n_edges, .spi_sclk, .spi_csb_n, .busy);
  always @(posedge clk_sys)
    if (channel_resync_command === 1'b1)
      n_pulse <= n_pulse + 1;
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // waitrequest is sampled at the rising edge; the request stands until it is seen low there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic push_e(input logic [17:0] d, input logic f, input logic h, input logic [2:0] g);
    @(posedge clk_sys);
    ecg_sample_valid <= 1'b1;
    ecg_sample_data <= d;
    ecg_sample_fast <= f;
    ecg_pace_hit <= h;
    ecg_pace_group <= g;
    @(posedge clk_sys);
    ecg_sample_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : push_e
  task automatic push_b(input logic [19:0] d, input logic o);
    @(posedge clk_sys);
    bioz_sample_valid <= 1'b1;
    bioz_sample_data <= d;
    bioz_out_of_range <= o;
    @(posedge clk_sys);
    bioz_sample_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : push_b
  task automatic frame(input logic [10:0] n);
    @(posedge clk_sys);
    n_edges <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(negedge clk_sys);
    while (busy !== 1'b0)
      @(negedge clk_sys);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : frame
  task automatic t_reset();
    @(negedge clk_sys);
    chk("ecg empty at reset", 32'h6, head_word[5:3]);
    bus(1'b0, 5'h0c, 32'h0);
    chk("status at reset", 32'h0, rd);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask : t_reset
  task automatic t_ecg_tags();
    push_e(18'h2abcd, 1'b1, 1'b1, 3'h5);
    chk("ecg fast last", {18'h2abcd, 3'h3, 3'h5}, head_word);
    push_e(18'h01234, 1'b0, 1'b0, 3'h2);
    frame(11'd31);
    chk("ecg fast no pop", {18'h2abcd, 3'h1, 3'h5}, head_word);
    frame(11'd32);
    chk("ecg last valid", {18'h01234, 3'h2, 3'h7}, head_word);
    frame(11'd32);
    chk("ecg empty", 32'h6, head_word[5:3]);
    frame(11'd32);
    push_e(18'h3ffff, 1'b0, 1'b1, 3'h6);
    chk("ecg after empty", {18'h3ffff, 3'h2, 3'h7}, head_word);
  endtask : t_ecg_tags
  task automatic t_pace();
    int i;
    for (i = 0; i < 6; i++)
      push_e(18'h00100, 1'b0, 1'b1, i[2:0]);
    frame(11'd32);
    for (i = 0; i < 6; i++)
    begin
      chk("pace group", i, head_word[2:0]);
      frame(11'd32);
    end
    for (i = 0; i < 5; i++)
      push_e(18'h00200, 1'b0, 1'b0, 3'h0);
    bus(1'b1, 5'h00, 32'h2);
    frame(11'd79);
    bus(1'b0, 5'h0c, 32'h0);
    chk("burst two pops", 32'h3, rd[13:8]);
    frame(11'd80);
    bus(1'b0, 5'h0c, 32'h0);
    chk("burst three pops", 32'h0, rd[13:8]);
    push_e(18'h00300, 1'b0, 1'b0, 3'h0);
  endtask : t_pace
  task automatic t_bioz();
    int i;
    bus(1'b1, 5'h00, 32'h1);
    bus(1'b1, 5'h04, 32'h200);
    bus(1'b0, 5'h04, 32'h0);
    chk("thresh readback", 32'h200, rd);
    bus(1'b0, 5'h00, 32'h0);
    chk("ctrl readback", 32'h1, rd);
    push_b(20'habcde, 1'b1);
    chk("bioz flagged last", {20'habcde, 1'b0, 3'h3}, head_word);
    push_b(20'h12345, 1'b0);
    chk("bioz flagged", {20'habcde, 1'b0, 3'h1}, head_word);
    chk("bioz int two", 32'h0, bioz_fill_interrupt);
    push_b(20'h54321, 1'b0);
    chk("bioz int three", 32'h1, bioz_fill_interrupt);
    frame(11'd32);
    chk("bioz valid", {20'h12345, 1'b0, 3'h0}, head_word);
    frame(11'd32);
    chk("bioz last valid", {20'h54321, 1'b0, 3'h2}, head_word);
    bus(1'b0, 5'h10, 32'h0);
    chk("head register", {20'h54321, 1'b0, 3'h2}, rd);
    bus(1'b0, 5'h08, 32'h0);
    chk("cmd reads zero", 32'h0, rd);
    frame(11'd32);
    chk("bioz empty", 32'h6, head_word[2:0]);
    for (i = 0; i < 8; i++)
      push_b(i[19:0], 1'b0);
    bus(1'b0, 5'h0c, 32'h0);
    chk("bioz full", 32'h8, rd[19:16]);
    chk("bioz no ovf", 32'h0, bioz_overrun_flag);
    push_b(20'h0f0f0, 1'b0);
    chk("bioz ovf flag", 32'h1, bioz_overrun_flag);
    chk("bioz ovf tag", 32'h7, head_word[2:0]);
    bus(1'b1, 5'h08, 32'h1);
    repeat (3) @(posedge clk_sys);
    bus(1'b0, 5'h0c, 32'h0);
    chk("status after clear", 32'h0, rd);
  endtask : t_bioz
  task automatic t_ecg_ovf();
    int i;
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h04, 32'h1f);
    for (i = 0; i < 31; i++)
      push_e(i[17:0], 1'b0, 1'b0, 3'h0);
    chk("ecg int 31", 32'h0, ecg_fill_interrupt);
    push_e(18'h0001f, 1'b0, 1'b0, 3'h0);
    chk("ecg int 32", 32'h1, ecg_fill_interrupt);
    chk("ecg no ovf", 32'h0, ecg_overrun_flag);
    push_e(18'h15555, 1'b0, 1'b0, 3'h0);
    chk("ecg ovf tag", 32'h7, head_word[5:3]);
    bus(1'b0, 5'h0c, 32'h0);
    chk("ecg ovf status", 32'h3, rd[1:0]);
    chk("ecg count", 32'h20, rd[13:8]);
    bus(1'b1, 5'h08, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk("resync pulses", 32'h1, n_pulse);
    bus(1'b0, 5'h0c, 32'h0);
    chk("status after resync", 32'h0, rd);
    push_e(18'h00777, 1'b0, 1'b0, 3'h0);
    chk("ecg after resync", {18'h00777, 3'h2, 3'h7}, head_word);
  endtask : t_ecg_ovf
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_ecg_tags();
    t_pace();
    t_bioz();
    t_ecg_ovf();
    close_out();
  end
endmodule : test_bsf_sample_fifo
